// ---- logic/cpsc_regs.vh ----
// Constants for the core cluster power state controller.
`ifndef CPSC_REGS_VH
`define CPSC_REGS_VH

// Core power state codes.
`define CPSC_ST_W             3
`define CPSC_ST_FULL_ON       3'h0
`define CPSC_ST_DOZE          3'h1
`define CPSC_ST_NAP           3'h2
`define CPSC_ST_RET_GATING    3'h3
`define CPSC_ST_UNRET_GATING  3'h4
`define CPSC_ST_WAIT_IDLE     3'h5
`define CPSC_ST_WAIT_GATED    3'h6

// Software request codes from the run-control power unit.
`define CPSC_REQ_W            3
`define CPSC_REQ_NONE         3'h0
`define CPSC_REQ_DOZE         3'h1
`define CPSC_REQ_NAP          3'h2
`define CPSC_REQ_RET_GATING   3'h3
`define CPSC_REQ_UNRET_GATING 3'h4

// Chip level states.
`define CPSC_CHIP_W           2
`define CPSC_CHIP_RUN         2'h0
`define CPSC_CHIP_ENTER       2'h1
`define CPSC_CHIP_SLEEP       2'h2
`define CPSC_CHIP_EXIT        2'h3

// Wait-idle cycles before the core is power gated, 1 us at 100 MHz.
`define CPSC_WAIT_GATE_NS     1000
`define CPSC_CLK_NS           10
`define CPSC_WAIT_GATE_CYC    (`CPSC_WAIT_GATE_NS / `CPSC_CLK_NS)
`define CPSC_CNT_W            8

`endif

// ---- logic/cpsc_core_fsm.v ----
// Per-core power state machine for the core cluster power state controller.
`timescale 1ns/1ps
`default_nettype none
`include "cpsc_regs.vh"

module cpsc_core_fsm (
    // Clock and reset.
    input  wire                     clk_sys,
    input  wire                     rst,
    // Requests: both thread wait flags and the software request.
    input  wire [1:0]               thread_wait,
    input  wire [`CPSC_REQ_W-1:0]   thread0_req,
    input  wire [`CPSC_REQ_W-1:0]   thread1_req,
    input  wire                     core_reset,
    // Wake sources.
    input  wire                     hw_event,
    input  wire                     irq,
    input  wire                     chip_indicator_out_a,
    // State and controls.
    output reg  [`CPSC_ST_W-1:0]    state_q,
    output reg                      fetch_en_q,
    output reg                      clk_en_q,
    output reg                      pwr_en_q,
    output reg                      retain_q,
    output reg                      snoop_en_q
);

    reg  [`CPSC_ST_W-1:0]  state_d;
    reg  [`CPSC_CNT_W-1:0] cnt_q;
    wire                   both_wait = &thread_wait;
    wire                   same_req  = (thread0_req == thread1_req);
    wire                   wake      = hw_event | irq;

    // =========================================================================
    // Next state.
    // =========================================================================
    always @* begin
        state_d = state_q;
        case (state_q)
            `CPSC_ST_FULL_ON: begin
                if (both_wait)
                    state_d = `CPSC_ST_WAIT_IDLE;
                else if (same_req) begin
                    case (thread0_req)
                        `CPSC_REQ_DOZE:         state_d = `CPSC_ST_DOZE;
                        `CPSC_REQ_NAP:          state_d = `CPSC_ST_NAP;
                        `CPSC_REQ_RET_GATING:   state_d = `CPSC_ST_RET_GATING;
                        `CPSC_REQ_UNRET_GATING: state_d = `CPSC_ST_UNRET_GATING;
                        default:                state_d = `CPSC_ST_FULL_ON;
                    endcase
                end
            end
            `CPSC_ST_DOZE, `CPSC_ST_NAP, `CPSC_ST_RET_GATING: begin
                // Retained states ignore wake events through chip sleep until the chip is back.
                if ((wake && !chip_indicator_out_a) || (same_req && thread0_req == `CPSC_REQ_NONE))
                    state_d = `CPSC_ST_FULL_ON;
            end
            `CPSC_ST_UNRET_GATING: begin
                if (core_reset)
                    state_d = `CPSC_ST_FULL_ON;
            end
            `CPSC_ST_WAIT_IDLE: begin
                if (wake || !both_wait)
                    state_d = `CPSC_ST_FULL_ON;
                else if (cnt_q == `CPSC_WAIT_GATE_CYC - 1)
                    state_d = `CPSC_ST_WAIT_GATED;
            end
            `CPSC_ST_WAIT_GATED: begin
                if (wake || !both_wait)
                    state_d = `CPSC_ST_FULL_ON;
            end
            default: state_d = `CPSC_ST_FULL_ON;
        endcase
    end

    // =========================================================================
    // State, idle counter and registered controls.
    // =========================================================================
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q    <= `CPSC_ST_FULL_ON;
            cnt_q      <= {`CPSC_CNT_W{1'b0}};
            fetch_en_q <= 1'b1;
            clk_en_q   <= 1'b1;
            pwr_en_q   <= 1'b1;
            retain_q   <= 1'b0;
            snoop_en_q <= 1'b1;
        end else begin
            state_q <= state_d;
            if (state_q == `CPSC_ST_WAIT_IDLE && state_d == `CPSC_ST_WAIT_IDLE)
                cnt_q <= cnt_q + 1'b1;
            else
                cnt_q <= {`CPSC_CNT_W{1'b0}};
            fetch_en_q <= (state_d == `CPSC_ST_FULL_ON);
            clk_en_q   <= (state_d == `CPSC_ST_FULL_ON) ||
                          (state_d == `CPSC_ST_DOZE) ||
                          (state_d == `CPSC_ST_WAIT_IDLE);
            pwr_en_q   <= !((state_d == `CPSC_ST_RET_GATING) ||
                            (state_d == `CPSC_ST_UNRET_GATING) ||
                            (state_d == `CPSC_ST_WAIT_GATED));
            retain_q   <= (state_d == `CPSC_ST_RET_GATING) ||
                          (state_d == `CPSC_ST_WAIT_GATED);
            snoop_en_q <= (state_d == `CPSC_ST_FULL_ON) ||
                          (state_d == `CPSC_ST_DOZE) ||
                          (state_d == `CPSC_ST_WAIT_IDLE);
        end
    end

endmodule
`default_nettype wire

// ---- logic/cpsc_power_ctrl.v ----
// Top of the core cluster power state controller: cores, cluster and chip.
// Summary of operation
// - Full-on keeps global clocks; unit clocks gate on per-unit busy.
// - Doze keeps clocks, stops fetch, still serves snoops.
// - Nap stops core clocks; software flushes caches first.
// - Retained gating removes power but keeps state.
// - Unretained gating ignores interrupts; only core reset returns full-on.
// - Both threads waiting gives wait-idle: clocks run, fetch stops.
// - Wait-idle moves to wait-gated in hardware after a fixed idle time.
// - Wait-gated wakes on any hardware event with no software restore.
// - Cluster clock-inhibit stops cluster clocks and shared cache snooping.
// - Partial low-power reported when any core is not full-on.
// - Deep sleep only with all cores retained-gated and cluster inhibited.
// - Deep sleep stops core, timebase and logic clocks, keeps wake logic.
// - Deep sleep wakes only on timers, internal or external interrupts.
// - Indicator_out_a output rises only after cores and I/O have shut down.
// - Core enters a software-requested state only when both threads ask for the same.
`timescale 1ns/1ps
`default_nettype none
`include "cpsc_regs.vh"

module cpsc_power_ctrl #(
    parameter NCORE = 4
) (
    // Clock and reset.
    input  wire                         clk_sys,
    input  wire                         rst,
    // Thread requests, two threads per core.
    input  wire [2*NCORE-1:0]           thread_wait,
    input  wire [2*NCORE*`CPSC_REQ_W-1:0] thread_req,
    input  wire [NCORE-1:0]             core_reset,
    input  wire [NCORE-1:0]             unit_busy,
    // Cluster and chip requests.
    input  wire                         cluster_inhibit_req,
    input  wire                         deep_sleep_req,
    // Wake sources, from pins or other domains.
    input  wire [NCORE-1:0]             core_hw_event,
    input  wire [NCORE-1:0]             core_irq,
    input  wire                         timer_wake,
    input  wire                         int_irq_wake,
    input  wire                         ext_irq_wake,
    // Shutdown acknowledge from cores and I/O interfaces.
    input  wire                         core_shutdown_done,
    input  wire                         io_shutdown_done,
    // Core controls.
    output wire [NCORE-1:0]             core_fetch_en,
    output wire [NCORE-1:0]             core_clk_en,
    output reg  [NCORE-1:0]             unit_clk_en_q,
    output wire [NCORE-1:0]             core_pwr_en,
    output wire [NCORE-1:0]             core_retain,
    output wire [NCORE-1:0]             core_snoop_en,
    output wire [NCORE*`CPSC_ST_W-1:0]  core_state,
    // Cluster, chip and pin controls.
    output reg                          cluster_clk_en_q,
    output reg                          l2_snoop_en_q,
    output reg                          platform_clk_en_q,
    output reg                          timebase_en_q,
    output reg                          io_shutdown_req_q,
    output reg                          chip_partial_low_power_q,
    output reg                          chip_deep_sleep_q,
    output reg                          indicator_out_a_q
);

    // =========================================================================
    // Synchronisers for inputs from outside the clock domain.
    // =========================================================================
    localparam SW = 3*NCORE + 5;
    wire [SW-1:0] raw = {core_hw_event, core_irq, core_reset, timer_wake, int_irq_wake,
                         ext_irq_wake, core_shutdown_done, io_shutdown_done};
    reg  [SW-1:0] s1_q;
    reg  [SW-1:0] s2_q;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_q <= {SW{1'b0}};
            s2_q <= {SW{1'b0}};
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end
    wire [NCORE-1:0] hw_ev_s  = s2_q[3*NCORE+4:2*NCORE+5];
    wire [NCORE-1:0] irq_s    = s2_q[2*NCORE+4:NCORE+5];
    wire [NCORE-1:0] creset_s = s2_q[NCORE+4:5];
    wire             timer_s  = s2_q[4];
    wire             iirq_s   = s2_q[3];
    wire             eirq_s   = s2_q[2];
    wire             cdone_s  = s2_q[1];
    wire             iodone_s = s2_q[0];

    // Only timers and interrupts may wake the chip from deep sleep.
    wire chip_wake = timer_s | iirq_s | eirq_s;

    // =========================================================================
    // Chip state machine.
    // =========================================================================
    reg  [`CPSC_CHIP_W-1:0] chip_q;
    reg  [`CPSC_CHIP_W-1:0] chip_d;
    wire [NCORE-1:0]        core_ret;
    wire [NCORE-1:0]        core_on;
    wire                    all_ret  = &core_ret;
    wire                    indicator_out_a   = (chip_q == `CPSC_CHIP_SLEEP);
    wire                    cl_inh_d = cluster_inhibit_req | (chip_q != `CPSC_CHIP_RUN);

    always @* begin
        chip_d = chip_q;
        case (chip_q)
            `CPSC_CHIP_RUN: begin
                if (deep_sleep_req && all_ret && !cluster_clk_en_q)
                    chip_d = `CPSC_CHIP_ENTER;
            end
            `CPSC_CHIP_ENTER: begin
                if (chip_wake)
                    chip_d = `CPSC_CHIP_EXIT;
                else if (cdone_s && iodone_s)
                    chip_d = `CPSC_CHIP_SLEEP;
            end
            `CPSC_CHIP_SLEEP: begin
                if (chip_wake)
                    chip_d = `CPSC_CHIP_EXIT;
            end
            `CPSC_CHIP_EXIT: chip_d = `CPSC_CHIP_RUN;
            default:         chip_d = `CPSC_CHIP_RUN;
        endcase
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chip_q                   <= `CPSC_CHIP_RUN;
            cluster_clk_en_q         <= 1'b1;
            l2_snoop_en_q            <= 1'b1;
            platform_clk_en_q        <= 1'b1;
            timebase_en_q            <= 1'b1;
            io_shutdown_req_q        <= 1'b0;
            chip_partial_low_power_q <= 1'b0;
            chip_deep_sleep_q        <= 1'b0;
            indicator_out_a_q        <= 1'b0;
            unit_clk_en_q            <= {NCORE{1'b1}};
        end else begin
            chip_q            <= chip_d;
            cluster_clk_en_q  <= !cl_inh_d;
            l2_snoop_en_q     <= !cl_inh_d;
            platform_clk_en_q <= (chip_d == `CPSC_CHIP_RUN) ||
                                 (chip_d == `CPSC_CHIP_EXIT);
            timebase_en_q     <= (chip_d != `CPSC_CHIP_SLEEP);
            io_shutdown_req_q <= (chip_d == `CPSC_CHIP_ENTER) || (chip_d == `CPSC_CHIP_SLEEP);
            chip_partial_low_power_q <= !(&core_on);
            chip_deep_sleep_q <= (chip_d == `CPSC_CHIP_SLEEP);
            indicator_out_a_q <= (chip_d == `CPSC_CHIP_SLEEP);
            unit_clk_en_q     <= unit_busy & core_on & {NCORE{!indicator_out_a}};
        end
    end

    // =========================================================================
    // Per-core state machines.
    // =========================================================================
    genvar g;
    generate
        for (g = 0; g < NCORE; g = g + 1) begin : core
            wire [`CPSC_ST_W-1:0] st;
            wire                  clk_en;
            cpsc_core_fsm u_fsm (
                .clk_sys     (clk_sys),
                .rst         (rst),
                .thread_wait (thread_wait[2*g+1:2*g]),
                .thread0_req (thread_req[(2*g+1)*`CPSC_REQ_W-1:2*g*`CPSC_REQ_W]),
                .thread1_req (thread_req[(2*g+2)*`CPSC_REQ_W-1:(2*g+1)*`CPSC_REQ_W]),
                .core_reset  (creset_s[g]),
                .hw_event    (hw_ev_s[g]),
                .irq         (irq_s[g]),
                .chip_indicator_out_a (chip_q != `CPSC_CHIP_RUN),
                .state_q     (st),
                .fetch_en_q  (core_fetch_en[g]),
                .clk_en_q    (clk_en),
                .pwr_en_q    (core_pwr_en[g]),
                .retain_q    (core_retain[g]),
                .snoop_en_q  (core_snoop_en[g])
            );
            // Deep sleep overrides every core clock.
            assign core_clk_en[g] = clk_en & !indicator_out_a;
            assign core_ret[g]    = (st == `CPSC_ST_RET_GATING);
            assign core_on[g]     = (st == `CPSC_ST_FULL_ON);
            assign core_state[(g+1)*`CPSC_ST_W-1:g*`CPSC_ST_W] = st;
        end
    endgenerate

endmodule
`default_nettype wire

// ---- sim/cpsc_power_ctrl_monitor.sv ----
// Concurrent checks on the ports of the power state controller.
`timescale 1ns/1ps
`default_nettype none
`include "cpsc_regs.vh"
module cpsc_power_ctrl_monitor #(
    parameter NCORE = 4
) (
    // Clock and reset.
    input wire logic                          clk_sys,
    input wire logic                          rst,
    // Wake and acknowledge inputs.
    input wire logic [NCORE-1:0]              core_reset,
    input wire logic [NCORE-1:0]              core_hw_event,
    input wire logic                          timer_wake,
    input wire logic                          int_irq_wake,
    input wire logic                          ext_irq_wake,
    input wire logic                          core_shutdown_done,
    input wire logic                          io_shutdown_done,
    // Core controls.
    input wire logic [NCORE-1:0]              core_fetch_en,
    input wire logic [NCORE-1:0]              core_clk_en,
    input wire logic [NCORE-1:0]              core_pwr_en,
    input wire logic [NCORE-1:0]              core_retain,
    input wire logic [NCORE-1:0]              core_snoop_en,
    input wire logic [NCORE*`CPSC_ST_W-1:0]   core_state,
    // Cluster and chip controls.
    input wire logic                          cluster_clk_en_q,
    input wire logic                          l2_snoop_en_q,
    input wire logic                          platform_clk_en_q,
    input wire logic                          timebase_en_q,
    input wire logic                          chip_partial_low_power_q,
    input wire logic                          chip_deep_sleep_q,
    input wire logic                          indicator_out_a_q
);
    // ==========================================================
    // Helper logic
    wire  [2:0] st0 = core_state[2:0];
    logic [7:0] idle_q;
    // Counts consecutive cycles of core 0 in wait-idle.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            idle_q <= 8'h00;
        end else begin
            idle_q <= (st0 == `CPSC_ST_WAIT_IDLE) ? idle_q + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_back_on;
        st0 == `CPSC_ST_FULL_ON && core_pwr_en[0];
    endsequence
    sequence s_ret_wake;
        st0 == `CPSC_ST_RET_GATING && core_hw_event[0] && platform_clk_en_q && !chip_deep_sleep_q;
    endsequence
    // ==========================================================
    // Assertions
    a_doze_fetch_stop: assert property (st0 == `CPSC_ST_DOZE |->
        !core_fetch_en[0] && core_clk_en[0] && core_snoop_en[0]) else $error("doze controls wrong");
    a_retained_power_off: assert property (st0 == `CPSC_ST_RET_GATING |->
        !core_pwr_en[0] && core_retain[0]) else $error("retained gating controls wrong");
    a_unretained_hold: assert property ((st0 == `CPSC_ST_UNRET_GATING && !core_reset[0])[*4] |=>
        st0 == `CPSC_ST_UNRET_GATING) else $error("unretained gating left without reset");
    a_wait_idle_run: assert property (st0 == `CPSC_ST_WAIT_IDLE |->
        core_clk_en[0] && !core_fetch_en[0]) else $error("wait-idle controls wrong");
    a_wait_gate_time: assert property (st0 == `CPSC_ST_WAIT_GATED && $past(st0) == `CPSC_ST_WAIT_IDLE |->
        idle_q >= 99 && idle_q <= 101 && !core_pwr_en[0] && core_retain[0]) else $error("wait gating wrong");
    a_wait_gate_bound: assert property (idle_q <= 8'h65) else $error("wait-idle held too long");
    a_gated_wake: assert property (st0 == `CPSC_ST_WAIT_GATED && core_hw_event[0] |->
        ##[1:4] s_back_on) else $error("wait-gated core not woken");
    a_inhibit_no_snoop: assert property (!cluster_clk_en_q |-> !l2_snoop_en_q) else $error("cache snoops");
    a_partial_report: assert property (core_state == $past(core_state) |->
        chip_partial_low_power_q == (core_state != 0)) else $error("partial low-power flag wrong");
    a_sleep_entry_ok: assert property ($rose(chip_deep_sleep_q) |-> core_state == 12'h6db
        && !cluster_clk_en_q && !platform_clk_en_q) else $error("deep sleep entered early");
    a_sleep_clocks_off: assert property (chip_deep_sleep_q |->
        !timebase_en_q && !platform_clk_en_q && core_clk_en == 0) else $error("clock runs in sleep");
    a_sleep_wake_only: assert property ((chip_deep_sleep_q && !timer_wake && !int_irq_wake
        && !ext_irq_wake)[*4] |=> chip_deep_sleep_q) else $error("sleep left without wake source");
    a_indicator_out_a_after_done: assert property ($rose(indicator_out_a_q) |->
        core_shutdown_done && io_shutdown_done && chip_deep_sleep_q) else $error("indicator_out_a pin early");
    a_retained_wake: assert property (s_ret_wake |-> ##[1:5] s_back_on) else $error("retained wake lost");
endmodule
bind cpsc_power_ctrl cpsc_power_ctrl_monitor #(.NCORE(NCORE)) u_monitor (
    .clk_sys(clk_sys), .rst(rst), .core_reset(core_reset), .core_hw_event(core_hw_event),
    .timer_wake(timer_wake), .int_irq_wake(int_irq_wake), .ext_irq_wake(ext_irq_wake),
    .core_shutdown_done(core_shutdown_done), .io_shutdown_done(io_shutdown_done),
    .core_fetch_en(core_fetch_en), .core_clk_en(core_clk_en), .core_pwr_en(core_pwr_en),
    .core_retain(core_retain), .core_snoop_en(core_snoop_en), .core_state(core_state),
    .cluster_clk_en_q(cluster_clk_en_q), .l2_snoop_en_q(l2_snoop_en_q), .platform_clk_en_q(platform_clk_en_q),
    .timebase_en_q(timebase_en_q), .chip_partial_low_power_q(chip_partial_low_power_q),
    .chip_deep_sleep_q(chip_deep_sleep_q), .indicator_out_a_q(indicator_out_a_q));
`default_nettype wire

// ---- sim/cpsc_far_model.sv ----
// Model of the cores and I/O interfaces that acknowledge a chip shutdown.
`timescale 1ns/1ps
`default_nettype none
module cpsc_far_model #(
    parameter DELAY = 6
) (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic rst,
    // Shutdown handshake.
    input  wire logic io_shutdown_req,
    output var  logic core_shutdown_done,
    output var  logic io_shutdown_done
);
    int wait_q;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wait_q <= 0;
        end else begin
            wait_q <= io_shutdown_req ? wait_q + 1 : 0;
        end
    end
    // The I/O side answers later than the cores, so the indicator_out_a pin must wait for the slower one.
    assign core_shutdown_done = io_shutdown_req && wait_q >= DELAY;
    assign io_shutdown_done = io_shutdown_req && wait_q >= 2 * DELAY;
endmodule
`default_nettype wire

// ---- sim/tb_core_cluster_soc_power_state_ctrl.sv ----
// Self-checking bench for the core cluster power state controller.
`timescale 1ns/1ps
`default_nettype none
`include "cpsc_regs.vh"
module tb_core_cluster_soc_power_state_ctrl;
    logic        clk_sys, rst, cluster_inhibit_req, deep_sleep_req, timer_wake, int_irq_wake, ext_irq_wake;
    logic [7:0]  thread_wait;
    logic [23:0] thread_req;
    logic [3:0]  core_reset, unit_busy, core_hw_event, core_irq;
    wire  [3:0]  core_fetch_en, core_clk_en, unit_clk_en_q, core_pwr_en, core_retain, core_snoop_en;
    wire  [11:0] core_state;
    wire         cluster_clk_en_q, l2_snoop_en_q, platform_clk_en_q, timebase_en_q, io_shutdown_req_q;
    wire         chip_partial_low_power_q, chip_deep_sleep_q, indicator_out_a_q, core_shutdown_done, io_shutdown_done;
    int          errors = 0, samples_checked = 0, cyc = 0, n;
    cpsc_power_ctrl #(.NCORE(4)) DUT (
        .clk_sys(clk_sys), .rst(rst), .thread_wait(thread_wait), .thread_req(thread_req), .core_reset(core_reset),
        .unit_busy(unit_busy), .cluster_inhibit_req(cluster_inhibit_req), .deep_sleep_req(deep_sleep_req),
        .core_hw_event(core_hw_event), .core_irq(core_irq), .timer_wake(timer_wake), .int_irq_wake(int_irq_wake),
        .ext_irq_wake(ext_irq_wake), .core_shutdown_done(core_shutdown_done), .io_shutdown_done(io_shutdown_done),
        .core_fetch_en(core_fetch_en), .core_clk_en(core_clk_en), .unit_clk_en_q(unit_clk_en_q),
        .core_pwr_en(core_pwr_en), .core_retain(core_retain), .core_snoop_en(core_snoop_en), .core_state(core_state),
        .cluster_clk_en_q(cluster_clk_en_q), .l2_snoop_en_q(l2_snoop_en_q), .platform_clk_en_q(platform_clk_en_q),
        .timebase_en_q(timebase_en_q), .io_shutdown_req_q(io_shutdown_req_q),
        .chip_partial_low_power_q(chip_partial_low_power_q), .chip_deep_sleep_q(chip_deep_sleep_q),
        .indicator_out_a_q(indicator_out_a_q));
    cpsc_far_model #(.DELAY(6)) u_far (.clk_sys(clk_sys), .rst(rst), .io_shutdown_req(io_shutdown_req_q),
        .core_shutdown_done(core_shutdown_done), .io_shutdown_done(io_shutdown_done));
    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    // Polls core c each cycle, so a state held for one cycle is still seen.
    task automatic wait_st(input int c, input logic [2:0] v, input int lim);
        n = 0;
        while (core_state[3*c +: 3] !== v && n < lim) begin
            step(1);
            n++;
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_doze();
        unit_busy = 4'h0;
        thread_req[11:0] = 12'h449;
        step(3);
        check("unit clock idle", 0, unit_clk_en_q[0]);
        check("core0 state", `CPSC_ST_DOZE, core_state[2:0]);
        check("core0 fetch clock snoop", 3'b011, {core_fetch_en[0], core_clk_en[0], core_snoop_en[0]});
        check("core1 mismatched", `CPSC_ST_FULL_ON, core_state[5:3]);
        check("partial flag", 1, chip_partial_low_power_q);
        thread_req = 24'h0;
        unit_busy = 4'hf;
        step(3);
        check("unit clock busy", 4'hf, unit_clk_en_q);
        check("partial flag clear", 0, chip_partial_low_power_q);
    endtask
    task automatic t_soft();
        for (int code = 2; code <= 4; code++) begin
            thread_req[5:0] = {code[2:0], code[2:0]};
            core_irq[0] = (code == 4);
            step(6);
            check("core0 state", code, core_state[2:0]);
            check("core0 clock", 0, core_clk_en[0]);
            check("core0 power retain", {code == 2, code == 3}, {core_pwr_en[0], core_retain[0]});
            thread_req[5:0] = (code == 3) ? thread_req[5:0] : 6'h00;
            step(4);
            check("core0 after withdraw", (code == 2) ? 0 : code, core_state[2:0]);
            {core_hw_event[0], core_reset[0]} = {code == 3, code == 4};
            wait_st(0, `CPSC_ST_FULL_ON, 8);
            {thread_req[5:0], core_hw_event[0], core_reset[0], core_irq[0]} = 9'h000;
            check("core0 woken", 1, n < 8);
            step(4);
        end
    endtask
    task automatic t_wait();
        thread_wait[1:0] = 2'b11;
        step(2);
        check("core0 wait idle", `CPSC_ST_WAIT_IDLE, core_state[2:0]);
        check("core0 fetch clock", 2'b01, {core_fetch_en[0], core_clk_en[0]});
        wait_st(0, `CPSC_ST_WAIT_GATED, 150);
        check("idle to gated cycles", 1, n >= `CPSC_WAIT_GATE_CYC - 2 && n <= `CPSC_WAIT_GATE_CYC);
        check("gated clock power", 2'b00, {core_clk_en[0], core_pwr_en[0]});
        core_hw_event[0] = 1'b1;
        wait_st(0, `CPSC_ST_FULL_ON, 6);
        {thread_wait[1:0], core_hw_event[0]} = 3'b000;
        check("gated core woken", 1, n < 6);
        step(3);
    endtask
    task automatic t_sleep();
        thread_req = 24'h6d_b6db;
        deep_sleep_req = 1'b1;
        step(8);
        check("all retained", 12'h6db, core_state);
        check("sleep refused", 0, chip_deep_sleep_q);
        // Software has flushed and invalidated the shared cache before this request.
        cluster_inhibit_req = 1'b1;
        step(2);
        check("cluster clock snoop", 2'b00, {cluster_clk_en_q, l2_snoop_en_q});
        for (int s = 0; s < 3; s++) begin
            deep_sleep_req = 1'b1;
            repeat (40) if (indicator_out_a_q !== 1'b1) step(1);
            check("indicator_out_a pin", 2'b11, {indicator_out_a_q, io_shutdown_req_q});
            check("sleep clocks", 0, {timebase_en_q, platform_clk_en_q, core_clk_en});
            {deep_sleep_req, core_hw_event, core_irq} = 9'h0ff;
            step(6);
            check("stays indicator_out_a", 1, chip_deep_sleep_q);
            {core_hw_event, core_irq} = 8'h00;
            {ext_irq_wake, int_irq_wake, timer_wake} = 3'b001 << s;
            repeat (8) if (indicator_out_a_q !== 1'b0) step(1);
            check("woken by source", 3'b100, {platform_clk_en_q, indicator_out_a_q, io_shutdown_req_q});
            {ext_irq_wake, int_irq_wake, timer_wake} = 3'b000;
            step(3);
        end
        {thread_req, cluster_inhibit_req} = 25'h0;
        step(6);
        check("cores back on", 12'h000, core_state);
        check("cluster clock", 1, cluster_clk_en_q);
    endtask
    // ==========================================================
    // Clock, timeout and main sequence
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        {rst, cluster_inhibit_req, deep_sleep_req, timer_wake, int_irq_wake, ext_irq_wake} = 6'h20;
        {thread_wait, thread_req, core_reset, core_hw_event, core_irq} = 44'h0;
        unit_busy = 4'hf;
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        step(1);
        t_doze();
        t_soft();
        t_wait();
        t_sleep();
        give_verdict();
    end
endmodule
`default_nettype wire
